// ===== core/rtcsf_regs.svh
// register map, field positions, reset values and timing counts
// assumes a 25 MHz core clock
`ifndef RTCSF_REGS_SVH
`define RTCSF_REGS_SVH

`define RTCSF_ADDR_SEC       4'h0
`define RTCSF_ADDR_MIN       4'h1
`define RTCSF_ADDR_HOUR      4'h2
`define RTCSF_ADDR_WDAY      4'h3
`define RTCSF_ADDR_CTRL2     4'hF

`define RTCSF_BIT_THRESH     7
`define RTCSF_BIT_SUPPLY_LOW 6
`define RTCSF_BIT_OSC_RUN    5
`define RTCSF_BIT_PON        4
`define RTCSF_BIT_CLKDIS_A   3
`define RTCSF_BIT_PIRQ       2
`define RTCSF_CMD_READ_BIT   3

`define RTCSF_SEC_MASK       8'h7F
`define RTCSF_HOUR_MASK      8'h3F
`define RTCSF_SEC_LAST       7'h59
`define RTCSF_HOUR_RESET     8'h12
`define RTCSF_WDAY_LAST      3'h6
`define RTCSF_HOUR_LAST_24   8'h23
`define RTCSF_HOUR_LAST_12   8'h31

`define RTCSF_PRESCALE_BITS  15
`define RTCSF_CLK_PERIOD_NS  40
`define RTCSF_ALARM_DELAY_NS 31000
`define RTCSF_ALARM_DELAY_CYC \
   ((`RTCSF_ALARM_DELAY_NS + `RTCSF_CLK_PERIOD_NS - 1) / `RTCSF_CLK_PERIOD_NS)

`endif

// ===== core/rtcsf_pkg.sv
// types and shared decoding for the rtc status and time counters
// assumes nothing beyond a SystemVerilog compiler
package rtcsf_pkg;

   typedef enum logic [2:0] {
      CT_OFF   = 3'h0,
      CT_LOW   = 3'h1,
      CT_HZ2   = 3'h2,
      CT_HZ1   = 3'h3,
      CT_SEC   = 3'h4,
      CT_MIN   = 3'h5,
      CT_HOUR  = 3'h6,
      CT_MONTH = 3'h7
   } rtcsf_ct_type;

   typedef enum logic {PH_CMD, PH_DATA} rtcsf_phase_type;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         return {4'(v[7:4] + 4'h1), 4'h0};
      end
      return {v[7:4], 4'(v[3:0] + 4'h1)};
   endfunction : bcd_inc

endpackage : rtcsf_pkg

// ===== core/rtcsf_bcd60.sv
// bcd counter 00..59 with carry, used for seconds and minutes
// assumes write and tick are one-cycle strobes on clk_in
`include "rtcsf_regs.svh"
module rtcsf_bcd60 (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // strobes and write data
   input  wire logic       tick_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] wdata_in,
   // count and carry
   output logic      [7:0] count_out,
   output logic            carry_out
);
   typedef struct packed {
      logic [6:0] count;
   } rtcsf_bcd60_state_type;

   rtcsf_bcd60_state_type s;
   rtcsf_bcd60_state_type next_s;
   logic [7:0]            wmask;

   assign wmask     = wdata_in & `RTCSF_SEC_MASK;
   assign count_out = {1'b0, s.count};
   assign carry_out = tick_in && !wr_in && s.count == `RTCSF_SEC_LAST;

   always_comb begin
      next_s = s;
      if (wr_in) begin
         next_s.count = wmask[6:0];
      end else if (tick_in) begin
         next_s.count = (s.count == `RTCSF_SEC_LAST) ? 7'h00
                        : 7'(rtcsf_pkg::bcd_inc({1'b0, s.count}));
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_wrap;
      tick_in && !wr_in && s.count == `RTCSF_SEC_LAST |-> carry_out ##1 s.count == 7'h00;
   endproperty
   a_wrap : assert property (p_wrap) else $error("count did not wrap at 59");

endmodule : rtcsf_bcd60

// ===== core/rtcsf_core.sv
// rtc status register, flags, sub clock gating and time counters
// assumes serial link pins, oscillator and sense inputs are synchronous to clk_in
`include "rtcsf_regs.svh"

module rtcsf_core #(
   parameter int PRE_W = `RTCSF_PRESCALE_BITS
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // four-wire serial link
   input  wire logic       ce_in,
   input  wire logic       sclk_in,
   input  wire logic       si_in,
   output logic            so_out,
   output logic            so_oe_n_out,
   // oscillator and analog sense
   input  wire logic       osc_in,
   input  wire logic       osc_halt_in,
   input  wire logic       supply_low_in,
   input  wire logic       power_on_in,
   // settings held in neighbouring registers
   input  wire logic       hour_mode_24_in,
   input  wire logic       clk_out_disable_b_in,
   input  wire logic [2:0] ct_sel_in,
   input  wire logic [1:0] alarm_enable_in,
   input  wire logic [1:0] alarm_match_in,
   input  wire logic       month_tick_in,
   // pins and side outputs
   output logic            irq_n_out,
   output logic            irq_oe_n_out,
   output logic            sub_clock_out,
   output logic            sub_clock_oe_n_out,
   output logic            supply_monitor_en_out,
   output logic            supply_thresh_out,
   output logic            ctrl_clear_out,
   output logic            day_carry_out
);
   localparam int         ALARM_DLY = `RTCSF_ALARM_DELAY_CYC;
   localparam logic [9:0] DLY_LAST  = 10'(ALARM_DLY - 1);

   if (PRE_W < 2 || ALARM_DLY > 1024) begin : g_bad_param
      $error("prescaler narrower than 2 bits or alarm delay too long");
   end

   typedef struct packed {
      rtcsf_pkg::rtcsf_phase_type phase;
      logic                       sclk_q;
      logic                       osc_q;
      logic [2:0]                 bit_cnt;
      logic [7:0]                 shift;
      logic [7:0]                 tx;
      logic [3:0]                 addr;
      logic                       rd;
      logic                       so;
      logic [PRE_W-1:0]           pre;
      logic [7:0]                 hour;
      logic [2:0]                 wday;
      logic                       thresh;
      logic                       supply_low;
      logic                       osc_run;
      logic                       power_on_flag;
      logic                       clkdis_a;
      logic                       pirq;
      logic [1:0]                 alarm_flag;
      logic [1:0]                 armed;
      logic [1:0][9:0]            dly;
      logic                       sub_clk;
      logic                       irq_n;
   } rtcsf_core_state_type;

   localparam rtcsf_core_state_type RESET_STATE = '{
      phase   : rtcsf_pkg::PH_CMD,
      hour    : `RTCSF_HOUR_RESET,
      power_on_flag     : 1'b1,
      sub_clk : 1'b1,
      irq_n   : 1'b1,
      default : '0
   };

   rtcsf_core_state_type s;
   rtcsf_core_state_type next_s;

   logic                    sclk_rise;
   logic                    sclk_fall;
   logic [7:0]              byte_in;
   logic                    wr_stb;
   logic                    sec_wr;
   logic                    min_wr;
   logic                    hour_wr;
   logic                    wday_wr;
   logic                    ctrl_wr;
   logic                    osc_rise;
   logic                    sec_tick;
   logic                    sec_carry;
   logic                    min_carry;
   logic                    day_carry;
   logic [7:0]              sec_count;
   logic [7:0]              min_count;
   logic [1:0]              alarm_seen;
   rtcsf_pkg::rtcsf_ct_type ct;

   assign sclk_rise = ce_in && sclk_in && !s.sclk_q;
   assign sclk_fall = ce_in && !sclk_in && s.sclk_q;
   assign byte_in   = {s.shift[6:0], si_in};
   assign wr_stb    = sclk_rise && s.bit_cnt == 3'h7 && s.phase == rtcsf_pkg::PH_DATA && !s.rd;
   assign sec_wr    = wr_stb && s.addr == `RTCSF_ADDR_SEC;
   assign min_wr    = wr_stb && s.addr == `RTCSF_ADDR_MIN;
   assign hour_wr   = wr_stb && s.addr == `RTCSF_ADDR_HOUR;
   assign wday_wr   = wr_stb && s.addr == `RTCSF_ADDR_WDAY;
   assign ctrl_wr   = wr_stb && s.addr == `RTCSF_ADDR_CTRL2;
   assign osc_rise  = osc_in && !s.osc_q;
   assign sec_tick  = osc_rise && (&s.pre) && !sec_wr;
   assign ct        = rtcsf_pkg::rtcsf_ct_type'(ct_sel_in);
   assign alarm_seen = s.alarm_flag & alarm_enable_in;

   // day carry in both hour formats
   assign day_carry = min_carry && !hour_wr
                      && s.hour == (hour_mode_24_in ? `RTCSF_HOUR_LAST_24 : `RTCSF_HOUR_LAST_12);

   rtcsf_bcd60 u_sec (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .tick_in   (sec_tick),
      .wr_in     (sec_wr),
      .wdata_in  (byte_in),
      .count_out (sec_count),
      .carry_out (sec_carry)
   );

   rtcsf_bcd60 u_min (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .tick_in   (sec_carry),
      .wr_in     (min_wr),
      .wdata_in  (byte_in),
      .count_out (min_count),
      .carry_out (min_carry)
   );

   // read image of one register; unmapped addresses read zero
   function automatic logic [7:0] read_reg(input logic [3:0] a);
      unique case (a)
         `RTCSF_ADDR_SEC   : return sec_count;
         `RTCSF_ADDR_MIN   : return min_count;
         `RTCSF_ADDR_HOUR  : return {2'b00, s.hour[5:0]};
         `RTCSF_ADDR_WDAY  : return {5'h00, s.wday};
         `RTCSF_ADDR_CTRL2 : return {s.thresh, s.supply_low, s.osc_run, s.power_on_flag,
                                     s.clkdis_a, s.pirq, alarm_seen};
         default           : return 8'h00;
      endcase
   endfunction : read_reg

   // hour step; bit 5 is pm in 12-hour mode, twenty digit otherwise
   function automatic logic [7:0] next_hour(input logic [7:0] h, input logic m24);
      if (m24) begin
         return (h == `RTCSF_HOUR_LAST_24) ? 8'h00 : rtcsf_pkg::bcd_inc(h);
      end
      unique case (h[4:0])
         5'h12   : return {2'b00, h[5], 5'h01};
         5'h11   : return {2'b00, !h[5], 5'h12};
         default : return {2'b00, h[5], 5'(rtcsf_pkg::bcd_inc({3'b000, h[4:0]}))};
      endcase
   endfunction : next_hour

   always_comb begin
      next_s        = s;
      next_s.sclk_q = sclk_in;
      next_s.osc_q  = osc_in;

      // serial slave: command byte then data bytes, address steps per byte
      if (!ce_in) begin
         next_s.phase   = rtcsf_pkg::PH_CMD;
         next_s.bit_cnt = 3'h0;
      end else if (sclk_rise) begin
         next_s.shift   = byte_in;
         next_s.bit_cnt = s.bit_cnt + 3'h1;
         if (s.bit_cnt == 3'h7) begin
            if (s.phase == rtcsf_pkg::PH_CMD) begin
               next_s.phase = rtcsf_pkg::PH_DATA;
               next_s.addr  = byte_in[7:4];
               next_s.rd    = byte_in[`RTCSF_CMD_READ_BIT];
               next_s.tx    = read_reg(byte_in[7:4]);
            end else begin
               next_s.addr = s.addr + 4'h1;
               next_s.tx   = read_reg(s.addr + 4'h1);
            end
         end
      end else if (sclk_fall && s.phase == rtcsf_pkg::PH_DATA && s.rd) begin
         next_s.so = s.tx[7];
         next_s.tx = {s.tx[6:0], 1'b0};
      end

      // sub-second prescaler
      if (sec_wr) begin
         next_s.pre = '0;
      end else if (osc_rise) begin
         next_s.pre = PRE_W'(s.pre + 1'b1);
      end

      // hours and weekday; values written are trusted to be valid
      if (hour_wr) begin
         next_s.hour = byte_in & `RTCSF_HOUR_MASK;
      end else if (min_carry) begin
         next_s.hour = next_hour(s.hour, hour_mode_24_in);
      end
      if (wday_wr) begin
         next_s.wday = byte_in[2:0];
      end else if (day_carry) begin
         next_s.wday = (s.wday == `RTCSF_WDAY_LAST) ? 3'h0 : s.wday + 3'h1;
      end

      // status writes; power-on, periodic and alarm sets below override a clear in the same cycle
      if (ctrl_wr) begin
         next_s.thresh   = byte_in[`RTCSF_BIT_THRESH];
         next_s.osc_run  = byte_in[`RTCSF_BIT_OSC_RUN];
         next_s.clkdis_a = byte_in[`RTCSF_BIT_CLKDIS_A];
         if (!byte_in[`RTCSF_BIT_SUPPLY_LOW]) begin
            next_s.supply_low = 1'b0;
         end
         if (!byte_in[`RTCSF_BIT_PON]) begin
            next_s.power_on_flag = 1'b0;
         end
         if (!byte_in[`RTCSF_BIT_PIRQ] && ct_sel_in[2]) begin
            next_s.pirq = 1'b0;
         end
         for (int i = 0; i < 2; i++) begin
            if (!byte_in[i]) begin
               next_s.alarm_flag[i] = 1'b0;
            end
         end
      end

      // monitoring runs only while the flag is clear
      if (supply_low_in && !s.supply_low) begin
         next_s.supply_low = 1'b1;
      end
      if (osc_halt_in) begin
         next_s.osc_run = 1'b0;
      end
      if (power_on_in) begin
         next_s.power_on_flag = 1'b1;
      end

      // periodic interrupt: pulse modes follow the prescaler phase
      unique case (ct)
         rtcsf_pkg::CT_OFF   : next_s.pirq = 1'b0;
         rtcsf_pkg::CT_LOW   : next_s.pirq = 1'b1;
         rtcsf_pkg::CT_HZ2   : next_s.pirq = !s.pre[PRE_W-2];
         rtcsf_pkg::CT_HZ1   : next_s.pirq = !s.pre[PRE_W-1];
         rtcsf_pkg::CT_SEC   : next_s.pirq = next_s.pirq || sec_tick;
         rtcsf_pkg::CT_MIN   : next_s.pirq = next_s.pirq || sec_carry;
         rtcsf_pkg::CT_HOUR  : next_s.pirq = next_s.pirq || min_carry;
         rtcsf_pkg::CT_MONTH : next_s.pirq = next_s.pirq || month_tick_in;
      endcase

      // alarm: delay after match, then latch flag
      for (int i = 0; i < 2; i++) begin
         if (!alarm_enable_in[i]) begin
            next_s.armed[i]      = 1'b0;
            next_s.alarm_flag[i] = 1'b0;
         end else if (alarm_match_in[i]) begin
            next_s.armed[i] = 1'b1;
            next_s.dly[i]   = 10'h000;
         end else if (s.armed[i]) begin
            if (s.dly[i] == DLY_LAST) begin
               next_s.armed[i]      = 1'b0;
               next_s.alarm_flag[i] = 1'b1;
            end else begin
               next_s.dly[i] = s.dly[i] + 10'h001;
            end
         end
      end

      // power-on holds control bits cleared, so the pin stays released
      if (next_s.power_on_flag) begin
         next_s.thresh     = 1'b0;
         next_s.supply_low = 1'b0;
         next_s.clkdis_a   = 1'b0;
         next_s.pirq       = 1'b0;
         next_s.alarm_flag = 2'b00;
         next_s.armed      = 2'b00;
      end

      next_s.sub_clk = (s.clkdis_a && clk_out_disable_b_in) ? 1'b1 : osc_in;
      next_s.irq_n   = !(next_s.pirq || (|next_s.alarm_flag));
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign so_out                = s.so;
   assign so_oe_n_out           = !(ce_in && s.phase == rtcsf_pkg::PH_DATA && s.rd);
   assign irq_n_out             = s.irq_n;
   assign irq_oe_n_out          = s.irq_n;
   assign sub_clock_out         = s.sub_clk;
   assign sub_clock_oe_n_out    = s.sub_clk;
   assign supply_monitor_en_out = !s.supply_low;
   assign supply_thresh_out     = s.thresh;
   assign ctrl_clear_out        = s.power_on_flag;
   assign day_carry_out         = day_carry;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_supply_hold;
      s.supply_low && !power_on_in && !(ctrl_wr && !byte_in[`RTCSF_BIT_SUPPLY_LOW])
      |=> s.supply_low;
   endproperty
   a_supply_hold : assert property (p_supply_hold) else $error("supply flag lost");

   property p_supply_clear;
      ctrl_wr && !byte_in[`RTCSF_BIT_SUPPLY_LOW] && s.supply_low
      |=> !s.supply_low && supply_monitor_en_out;
   endproperty
   a_supply_clear : assert property (p_supply_clear) else $error("supply flag not cleared");

   property p_osc_halt;
      osc_halt_in |=> !s.osc_run;
   endproperty
   a_osc_halt : assert property (p_osc_halt) else $error("running flag not forced low");

   property p_pon_set;
      power_on_in |=> s.power_on_flag && ctrl_clear_out;
   endproperty
   a_pon_set : assert property (p_pon_set) else $error("power-on flag not set");

   property p_pon_clears;
      s.power_on_flag |-> !s.pirq && s.alarm_flag == 2'b00 && !s.clkdis_a && s.irq_n;
   endproperty
   a_pon_clears : assert property (p_pon_clears) else $error("control bits live under pon");

   property p_pon_stays_clear;
      !s.power_on_flag && !power_on_in |=> !s.power_on_flag;
   endproperty
   a_pon_stays_clear : assert property (p_pon_stays_clear) else $error("pon set by write");

   property p_sub_clock;
      !(s.clkdis_a && clk_out_disable_b_in) |=> s.sub_clk == $past(osc_in);
   endproperty
   a_sub_clock : assert property (p_sub_clock) else $error("sub clock gated wrongly");

   property p_pirq_pin;
      s.pirq |-> !irq_n_out;
   endproperty
   a_pirq_pin : assert property (p_pirq_pin) else $error("periodic flag without pin low");

   property p_alarm_delay;
      alarm_enable_in[1] && s.armed[1] && s.dly[1] == DLY_LAST && !alarm_match_in[1]
      && !power_on_in |=> s.alarm_flag[1] && !irq_n_out;
   endproperty
   a_alarm_delay : assert property (p_alarm_delay) else $error("alarm flag not set on time");

   property p_alarm_masked;
      !alarm_enable_in[0] |-> alarm_seen[0] == 1'b0 ##1 !s.alarm_flag[0];
   endproperty
   a_alarm_masked : assert property (p_alarm_masked) else $error("alarm flag seen while off");

   property p_pre_reset;
      sec_wr |=> s.pre == '0;
   endproperty
   a_pre_reset : assert property (p_pre_reset) else $error("prescaler not reset");

   property p_wday_wrap;
      day_carry && !wday_wr && s.wday == `RTCSF_WDAY_LAST |=> s.wday == 3'h0;
   endproperty
   a_wday_wrap : assert property (p_wday_wrap) else $error("weekday did not wrap");

endmodule : rtcsf_core

// ===== test/rtcsf_host.sv
// host model driving the four-wire serial link of the rtc core
// assumes clk_in is the core clock; sclk phases last 3 core clocks, the last high phase of a frame 5
module rtcsf_host (
   // clock
   input  wire logic clk_in,
   // serial link
   output logic      ce_out,
   output logic      sclk_out,
   output logic      si_out,
   input  wire logic so_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // sclk idles low outside frames
   initial begin
      ce_out = 1'b0;
      sclk_out = 1'b0;
      si_out = 1'b0;
   end
   // msb first; data sampled on the rise, so settled since the fall
   task automatic shift(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_in) sclk_out <= 1'b0;
         si_out <= d[i];
         repeat (3) @(posedge clk_in);
         sclk_out <= 1'b1;
         q[i] = so_in;
         repeat (2) @(posedge clk_in);
      end
   endtask : shift
   // one command byte and one whole data byte per frame
   task automatic access(input logic [3:0] a, input logic rd,
                         input logic [7:0] wd, output logic [7:0] q);
      logic [7:0] junk;
      @(posedge clk_in) ce_out <= 1'b1;
      shift({a, rd, 3'h0}, junk);
      shift(wd, q);
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      ce_out <= 1'b0;
      @(posedge clk_in);
   endtask : access
endmodule : rtcsf_host

// ===== test/rtcsf_core_tb_top.sv
// bench for the rtc flags and time counters, one task per scenario
// assumes rtcsf_host on the link; prescaler cut to 5 bits for speed
`include "rtcsf_regs.svh"
module rtcsf_core_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] ctl = `RTCSF_ADDR_CTRL2;
   logic       clk_in, rst_in, ce_in, sclk_in, si_in, so_out, osc_in;
   logic       osc_halt_in, supply_low_in, power_on_in, hour_mode_24_in;
   logic       clk_out_disable_b_in, irq_n_out, sub_clock_out, day_carry_out;
   logic       supply_monitor_en_out, supply_thresh_out, ctrl_clear_out;
   logic       so_oe_n_out, irq_oe_n_out, sub_clock_oe_n_out;
   logic [2:0] ct_sel_in;
   logic [1:0] alarm_enable_in, alarm_match_in;
   int         miscompares = 0, cmp_count = 0, cyc = 0;

   rtcsf_core #(.PRE_W(5)) DUT (.month_tick_in(1'b0), .*);
   rtcsf_host host_i (.clk_in(clk_in), .ce_out(ce_in), .sclk_out(sclk_in),
      .si_out(si_in), .so_in(so_out));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // one second is 32 osc rises of 20 clocks, 640 clocks
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      osc_in <= (cyc % 20) >= 10;
      if (cyc == 40000) begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      host_i.access(a, 1'b0, d, q);
   endtask : wr
   task automatic rdc(input string w, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      host_i.access(a, 1'b1, 8'h00, q);
      check(w, q, e);
   endtask : rdc
   task automatic wait_low(input int n);
      for (int k = 0; k < n && irq_n_out !== 1'b0; k++) @(posedge clk_in);
   endtask : wait_low
   task automatic match(input logic [1:0] m);
      @(posedge clk_in) alarm_match_in <= m;
      @(posedge clk_in) alarm_match_in <= 2'h0;
   endtask : match

   task automatic t_power();
      check("ctrl_clear", 8'(ctrl_clear_out), 8'h01);
      check("so_oe_n", 8'(so_oe_n_out), 8'h01);
      check("irq_oe_n", 8'(irq_oe_n_out), 8'h01);
      rdc("ctrl2", ctl, 8'h10);
      rdc("hour", 4'h2, 8'h12);
      wr(ctl, 8'hFF);
      rdc("ctrl2", ctl, 8'h30);
      wr(4'h7, 8'h55);
      rdc("unmapped", 4'h7, 8'h00);
      wr(ctl, 8'h00);
      rdc("ctrl2", ctl, 8'h00);
      check("ctrl_clear", 8'(ctrl_clear_out), 8'h00);
      @(posedge clk_in) power_on_in <= 1'b1;
      @(posedge clk_in) power_on_in <= 1'b0;
      wr(ctl, 8'h1C);
      rdc("ctrl2", ctl, 8'h10);
      wr(ctl, 8'h00);
      $display("test power done");
   endtask : t_power
   task automatic t_supply();
      supply_low_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      supply_low_in <= 1'b0;
      rdc("ctrl2", ctl, 8'h40);
      check("mon_en", 8'(supply_monitor_en_out), 8'h00);
      wr(ctl, 8'h40);
      rdc("ctrl2", ctl, 8'h40);
      wr(ctl, 8'h80);
      check("mon_en", 8'(supply_monitor_en_out), 8'h01);
      check("thresh", 8'(supply_thresh_out), 8'h01);
      rdc("ctrl2", ctl, 8'h80);
      wr(ctl, 8'h20);
      rdc("ctrl2", ctl, 8'h20);
      @(posedge clk_in) osc_halt_in <= 1'b1;
      @(posedge clk_in) osc_halt_in <= 1'b0;
      rdc("ctrl2", ctl, 8'h00);
      wr(ctl, 8'h00);
      $display("test supply done");
   endtask : t_supply
   task automatic t_subclk();
      int n, m;
      for (int i = 0; i < 4; i++) begin
         wr(ctl, {4'h0, i[0], 3'h0});
         clk_out_disable_b_in <= i[1];
         n = 0;
         m = 0;
         repeat (40) @(posedge clk_in) begin
            n += (sub_clock_out !== 1'b1);
            m += (sub_clock_oe_n_out !== sub_clock_out);
         end
         check("subclk_idle", 8'(n == 0), 8'(i == 3));
         check("subclk_oe_n", 8'(m), 8'h00);
      end
      wr(ctl, 8'h00);
      $display("test subclk done");
   endtask : t_subclk
   task automatic t_periodic();
      int n;
      ct_sel_in <= 3'h4;
      wait_low(700);
      check("irq_n", 8'(irq_n_out), 8'h00);
      check("irq_oe_n", 8'(irq_oe_n_out), 8'h00);
      rdc("ctrl2", ctl, 8'h04);
      wr(ctl, 8'h04);
      check("irq_n", 8'(irq_n_out), 8'h00);
      wr(ctl, 8'h00);
      check("irq_n", 8'(irq_n_out), 8'h01);
      rdc("ctrl2", ctl, 8'h00);
      wait_low(700);
      check("irq_n", 8'(irq_n_out), 8'h00);
      // fixed low, then 2 Hz and 1 Hz at half duty over one full second
      for (int c = 1; c < 4; c++) begin
         ct_sel_in <= 3'(c);
         repeat (2) @(posedge clk_in);
         n = 0;
         repeat (640) @(posedge clk_in) if (irq_n_out === 1'b0) n++;
         check("low_time", 8'(n / 4), (c == 1) ? 8'hA0 : 8'h50);
      end
      ct_sel_in <= 3'h0;
      wr(ctl, 8'h00);
      $display("test periodic done");
   endtask : t_periodic
   task automatic t_alarm();
      logic [1:0] m;
      for (int i = 0; i < 2; i++) begin
         m = 2'(1 << i);
         alarm_enable_in <= m;
         match(m);
         repeat (770) @(posedge clk_in);
         check("irq_n", 8'(irq_n_out), 8'h01);
         wait_low(12);
         check("irq_n", 8'(irq_n_out), 8'h00);
         rdc("ctrl2", ctl, {6'h0, m});
         wr(ctl, {6'h0, m});
         rdc("ctrl2", ctl, {6'h0, m});
         wr(ctl, 8'h00);
         check("irq_n", 8'(irq_n_out), 8'h01);
         match(m);
         repeat (790) @(posedge clk_in);
         alarm_enable_in <= 2'h0;
         rdc("ctrl2", ctl, 8'h00);
      end
      $display("test alarm done");
   endtask : t_alarm
   task automatic t_roll();
      int n;
      for (int i = 0; i < 2; i++) begin
         hour_mode_24_in <= (i == 0);
         ct_sel_in <= i ? 3'h6 : 3'h5;
         wr(4'h3, i ? 8'h00 : 8'h06);
         wr(4'h2, i ? 8'h31 : 8'h23);
         wr(4'h1, 8'h59);
         wr(4'h0, 8'h59);
         check("irq_n", 8'(irq_n_out), 8'h01);
         n = 0;
         repeat (700) @(posedge clk_in) if (day_carry_out === 1'b1) n++;
         check("day_carry", 8'(n), 8'h01);
         check("irq_n", 8'(irq_n_out), 8'h00);
         ct_sel_in <= 3'h0;
         rdc("sec", 4'h0, 8'h00);
         rdc("min", 4'h1, 8'h00);
         rdc("hour", 4'h2, i ? 8'h12 : 8'h00);
         rdc("wday", 4'h3, i ? 8'h01 : 8'h00);
      end
      $display("test roll done");
   endtask : t_roll
   task automatic t_prescale();
      wr(4'h0, 8'h30);
      repeat (400) @(posedge clk_in);
      wr(4'h0, 8'h30);
      repeat (400) @(posedge clk_in);
      rdc("sec", 4'h0, 8'h30);
      repeat (300) @(posedge clk_in);
      rdc("sec", 4'h0, 8'h31);
      wr(4'h0, 8'h92);
      rdc("sec", 4'h0, 8'h12);
      wr(4'h3, 8'hFA);
      rdc("wday", 4'h3, 8'h02);
      wr(4'h2, 8'hE5);
      rdc("hour", 4'h2, 8'h25);
      $display("test prescale done");
   endtask : t_prescale

   initial begin
      rst_in = 1'b1;
      osc_halt_in = 1'b0;
      supply_low_in = 1'b0;
      power_on_in = 1'b0;
      hour_mode_24_in = 1'b0;
      clk_out_disable_b_in = 1'b0;
      ct_sel_in = 3'h0;
      alarm_enable_in = 2'h0;
      alarm_match_in = 2'h0;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_power();
      t_supply();
      t_subclk();
      t_periodic();
      t_alarm();
      t_roll();
      t_prescale();
      report_and_stop();
   end
endmodule : rtcsf_core_tb_top
